// ===== core/sbpr_consts.svh
// constants for the serial bus phy base register bank
// assumes inclusion by bare name from the package only; the design module sees it through the package
`ifndef SBPR_CONSTS_SVH
`define SBPR_CONSTS_SVH

// ==========================================================================
// register indices (byte address = 4 * index)
`define SBPR_IDX_LINK_CFG   4'h4
`define SBPR_IDX_EVENT      4'h5
`define SBPR_IDX_PAGE_PORT  4'h7
`define SBPR_IDX_PORT_STAT  4'h8
`define SBPR_IDX_PORT_CTRL  4'h9
`define SBPR_PAGE_PORT      3'h0

// ==========================================================================
// field positions, bit 7 is the leftmost printed bit
`define SBPR_B_LINK_ACTIVE_CONTROL        7
`define SBPR_B_CONT         6
`define SBPR_B_JIT_HI       5
`define SBPR_B_JIT_LO       3
`define SBPR_B_PWR_HI       2
`define SBPR_B_PWR_LO       0
`define SBPR_B_WDOG         7
`define SBPR_B_SHORT_RESET_REQUEST         6
`define SBPR_B_LOOP         5
`define SBPR_B_PFAIL        4
`define SBPR_B_TOUT         3
`define SBPR_B_PEVT         2
`define SBPR_B_ACCEL        1
`define SBPR_B_MULTI        0
`define SBPR_B_PAGE_HI      7
`define SBPR_B_PAGE_LO      5
`define SBPR_B_PORT_HI      3
`define SBPR_B_PORT_LO      0
`define SBPR_B_CON          2
`define SBPR_B_BIAS         1
`define SBPR_B_DIS          0
`define SBPR_B_INTEN        4
`define SBPR_B_FAULT        3

// ==========================================================================
// reset values and fixed fields
`define SBPR_RST_LINK_ACTIVE_CONTROL      1'h1
`define SBPR_JITTER_VAL     3'h0
`define SBPR_RST_PAGE       3'h0
`define SBPR_RST_PORT       4'h0
// filtered pins {link power, cable power, class}: link down, cable good
`define SBPR_PIN_IDLE       5'h08
`define SBPR_PC_LOAD_CYC    2'h3

// ==========================================================================
// timing
`define SBPR_CLK_PERIOD_PS  4000
`define SBPR_SHORT_RST_NS   1300
`define SBPR_SHORT_RST_CYC  ((`SBPR_SHORT_RST_NS * 1000 + `SBPR_CLK_PERIOD_PS - 1) / \
                             `SBPR_CLK_PERIOD_PS)

`endif

// ===== core/sbpr_pkg.sv
// types shared by the base register bank and its bench
// assumes sbpr_consts.svh is on the include path
package sbpr_pkg;
   `include "sbpr_consts.svh"

   // configuration carried to the phy core and self-id builder
   typedef struct packed {
      logic       link_active_selfid;
      logic       contender;
      logic [2:0] pwr_class;
      logic       accel_en;
      logic       multi_en;
   } sbpr_cfg_t;

   // debounced status of one port from the phy core
   typedef struct packed {
      logic bias;
      logic con;
      logic fault;
   } sbpr_port_t;

   typedef enum logic {SR_IDLE, SR_RUN} sbpr_sr_state_t;
endpackage

// ===== core/sbpr_base_regs.sv
// base configuration registers of a two-port cable phy, ahb-lite slave
// assumes one 250 MHz clock, phy core events as one-cycle pulses on this clock
`timescale 1ns/10ps

// Overview of operation
// - link-active control bit resets to 1, bus reset leaves it alone
// - link interface enable follows only the link power status input
// - self-id link-active is power status AND link-active control
// - writable contender bit copied into self-id
// - read-only 3-bit jitter field, reads zero
// - writable power class, loaded from pins at system reset
// - resume start sets port event when resume enable is set
// - short reset request starts 1.3 us short bus reset; bus reset clears it
// - loop flag set by tree-id arbitration timeout, write one clears
// - loop flag with resume enable and inactive link wakes the link
// - loop nodes raise loop flag, others raise state timeout and bus reset
// - cable power fail flag set on falling cable power status
// - state timeout sets flag and requests a bus reset
// - enabled port status change sets port event flag
// - acceleration enable drives accelerated arbitration and fly-by
// - multispeed enable allows mixed-speed concatenation
// - 3-bit page selector picks page for indices 8 and 9
// - 4-bit port selector picks port for per-port pages
// - page 0 maps selected port status; absent port reads zero
module sbpr_base_regs
   import sbpr_pkg::*;
#(
   parameter int NPORTS = 2
) (
   input  wire logic                    CLK_SYS_I,            // 250 MHz clock
   input  wire logic                    SYS_RST_I,            // sync reset, high
   input  wire logic                    HSEL_I,               // ahb slave select
   input  wire logic [31:0]             HADDR_I,              // ahb address
   input  wire logic [1:0]              HTRANS_I,             // ahb transfer type
   input  wire logic                    HWRITE_I,             // ahb write
   input  wire logic [2:0]              HSIZE_I,              // ahb size, word only
   input  wire logic [31:0]             HWDATA_I,             // ahb write data
   input  wire logic                    HREADY_I,             // ahb bus ready
   output logic [31:0]                  HRDATA_O,             // ahb read data
   output logic                         HREADYOUT_O,          // ahb slave ready
   output logic                         HRESP_O,              // always okay
   input  wire logic                    LINK_POWER_STATUS_I,  // pin, link powered
   input  wire logic                    CABLE_POWER_STATUS_I, // pin, cable power ok
   input  wire logic [2:0]              POWER_CLASS_PINS_I,   // pins, reset class
   input  wire logic                    TREE_ID_TIMEOUT_I,    // arb timeout pulse
   input  wire logic                    STATE_TIMEOUT_I,      // state timeout pulse
   input  wire logic                    BUS_RESET_I,          // bus reset seen pulse
   input  wire logic                    ARB_OPPORTUNITY_I,    // may start reset now
   input  wire logic [NPORTS-1:0]       RESUME_START_I,       // resume begins pulse
   input  wire sbpr_port_t [NPORTS-1:0] PORT_STAT_I,          // port status
   output sbpr_cfg_t                    CFG_O,                // config to core
   output logic                         LINK_IF_EN_O,         // link interface on
   output logic                         LINK_WAKE_O,          // activate link
   output logic                         SHORT_RESET_O,        // short reset active
   output logic                         STATE_RESET_REQ_O,    // bus reset pulse
   output logic [NPORTS-1:0]            PORT_DIS_O            // port disabled
);

   localparam int SR_CYC = `SBPR_SHORT_RST_CYC;
   localparam int SRW    = $clog2(SR_CYC + 1);

   // ========================================================================
   // pin synchronisers
   // ========================================================================
   localparam int NPIN = 5;
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_s2_q;
   logic [NPIN-1:0] pin_s3_q;
   logic [NPIN-1:0] pin_q;
   logic [1:0]      pc_ld_q;
   logic            lps_q;
   logic            cps_q;
   logic            cps_fall;

   // no reset on the chain so the power class pins are caught around reset
   always_ff @(posedge CLK_SYS_I) begin
      pin_s1_q <= {LINK_POWER_STATUS_I, CABLE_POWER_STATUS_I, POWER_CLASS_PINS_I};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
   end

   // a level is taken only once second and third stages agree; idle until then
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         pin_q   <= `SBPR_PIN_IDLE;
         pc_ld_q <= `SBPR_PC_LOAD_CYC;
      end else begin
         pc_ld_q <= pc_ld_q - 2'(pc_ld_q != 2'h0);
         for (int i = 0; i < NPIN; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   assign lps_q = pin_q[4];
   assign cps_q = pin_q[3];

   logic cps_prev_q;
   always_ff @(posedge CLK_SYS_I) begin
      cps_prev_q <= SYS_RST_I ? 1'h1 : cps_q;
   end
   assign cps_fall = cps_prev_q & ~cps_q;

   // ========================================================================
   // ahb-lite slave
   // ========================================================================
   logic       dp_wr_q;
   logic       dp_rd_q;
   logic       rd_done_q;
   logic [3:0] dp_idx_q;
   logic       dp_map_q;
   logic       addr_take;
   logic [7:0] rd_mux;
   logic       wr_event;
   logic [7:0] wd;

   assign addr_take = HSEL_I & HTRANS_I[1] & HREADY_I;

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         dp_wr_q  <= 1'h0;
         dp_rd_q  <= 1'h0;
         dp_idx_q <= 4'h0;
         dp_map_q <= 1'h0;
      end else if (HREADYOUT_O) begin
         dp_wr_q  <= addr_take & HWRITE_I;
         dp_rd_q  <= addr_take & ~HWRITE_I;
         dp_idx_q <= HADDR_I[5:2];
         dp_map_q <= (HADDR_I[31:6] == 26'h0) && (HADDR_I[1:0] == 2'h0);
      end
   end

   // reads take one wait state so a write just before is already visible
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         rd_done_q <= 1'h0;
         HRDATA_O  <= 32'h0;
      end else if (dp_rd_q && !rd_done_q) begin
         rd_done_q <= 1'h1;
         HRDATA_O  <= {24'h0, dp_map_q ? rd_mux : 8'h0};
      end else begin
         rd_done_q <= 1'h0;
      end
   end

   assign HREADYOUT_O = ~(dp_rd_q & ~rd_done_q);
   assign HRESP_O     = 1'h0;
   assign wd          = HWDATA_I[7:0];

   function automatic logic wr_to(input logic [3:0] idx);
      return dp_wr_q && dp_map_q && (dp_idx_q == idx);
   endfunction

   assign wr_event = wr_to(`SBPR_IDX_EVENT);

   // ========================================================================
   // configuration registers
   // ========================================================================
   logic       link_active_control_q;
   logic       cont_q;
   logic [2:0] pwr_q;
   logic       wdog_q;
   logic       accel_q;
   logic       multi_q;
   logic [2:0] page_q;
   logic [3:0] port_sel_q;

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         link_active_control_q <= `SBPR_RST_LINK_ACTIVE_CONTROL;
         cont_q  <= 1'h0;
         pwr_q   <= pin_s3_q[2:0];
      end else if (wr_to(`SBPR_IDX_LINK_CFG)) begin
         link_active_control_q <= wd[`SBPR_B_LINK_ACTIVE_CONTROL];
         cont_q  <= wd[`SBPR_B_CONT];
         pwr_q   <= wd[`SBPR_B_PWR_HI:`SBPR_B_PWR_LO];
      end else if (pc_ld_q != 2'h0) begin
         pwr_q   <= pin_s3_q[2:0];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         wdog_q  <= 1'h0;
         accel_q <= 1'h0;
         multi_q <= 1'h0;
      end else if (wr_event) begin
         wdog_q  <= wd[`SBPR_B_WDOG];
         accel_q <= wd[`SBPR_B_ACCEL];
         multi_q <= wd[`SBPR_B_MULTI];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         page_q     <= `SBPR_RST_PAGE;
         port_sel_q <= `SBPR_RST_PORT;
      end else if (wr_to(`SBPR_IDX_PAGE_PORT)) begin
         page_q     <= wd[`SBPR_B_PAGE_HI:`SBPR_B_PAGE_LO];
         port_sel_q <= wd[`SBPR_B_PORT_HI:`SBPR_B_PORT_LO];
      end
   end

   // ========================================================================
   // per-port control and change detection
   // ========================================================================
   logic              port_hit;
   logic [NPORTS-1:0] dis_q;
   logic [NPORTS-1:0] inten_q;
   logic [NPORTS-1:0] port_chg;

   assign port_hit = (page_q == `SBPR_PAGE_PORT) && (port_sel_q < 4'(NPORTS));

   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      logic [3:0] now;
      logic [3:0] prev_q;
      logic       sel;
      // bias is ignored while the port is disabled
      assign now = {PORT_STAT_I[p].bias & ~dis_q[p], PORT_STAT_I[p].con,
                    dis_q[p], PORT_STAT_I[p].fault};
      assign sel = port_hit && (port_sel_q == 4'(p));

      always_ff @(posedge CLK_SYS_I) begin
         if (SYS_RST_I) begin
            dis_q[p]   <= 1'h0;
            inten_q[p] <= 1'h0;
         end else begin
            if (sel && wr_to(`SBPR_IDX_PORT_STAT)) begin
               dis_q[p] <= wd[`SBPR_B_DIS];
            end
            if (sel && wr_to(`SBPR_IDX_PORT_CTRL)) begin
               inten_q[p] <= wd[`SBPR_B_INTEN];
            end
         end
      end

      always_ff @(posedge CLK_SYS_I) begin
         prev_q <= now;
      end
      assign port_chg[p] = inten_q[p] && (now != prev_q) && !SYS_RST_I;
   end

   assign PORT_DIS_O = dis_q;

   // ========================================================================
   // short arbitrated bus reset
   // ========================================================================
   sbpr_sr_state_t sr_state_q;
   logic [SRW-1:0] sr_cnt_q;
   logic           short_reset_request_q;
   logic           sr_start;

   assign sr_start = (sr_state_q == SR_IDLE) && short_reset_request_q && ARB_OPPORTUNITY_I;

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         sr_state_q <= SR_IDLE;
         sr_cnt_q   <= '0;
      end else begin
         case (sr_state_q)
            SR_IDLE: begin
               if (sr_start) begin
                  sr_state_q <= SR_RUN;
                  sr_cnt_q   <= SRW'(SR_CYC - 1);
               end
            end
            SR_RUN: begin
               if (sr_cnt_q == '0) begin
                  sr_state_q <= SR_IDLE;
               end else begin
                  sr_cnt_q <= sr_cnt_q - 1'b1;
               end
            end
            default: sr_state_q <= SR_IDLE;
         endcase
      end
   end

   assign SHORT_RESET_O = (sr_state_q == SR_RUN);

   // any bus reset, including our own, drops the request
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         short_reset_request_q <= 1'h0;
      end else if (sr_start || BUS_RESET_I || STATE_TIMEOUT_I) begin
         short_reset_request_q <= 1'h0;
      end else if (wr_event && wd[`SBPR_B_SHORT_RESET_REQUEST]) begin
         short_reset_request_q <= 1'h1;
      end
   end

   // ========================================================================
   // event flags, write one to clear, hardware set wins
   // ========================================================================
   logic loop_q;
   logic pfail_q;
   logic tout_q;
   logic pevt_q;
   logic pevt_set;

   assign pevt_set = (|port_chg) || (wdog_q && (|RESUME_START_I));

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         loop_q  <= 1'h0;
         pfail_q <= 1'h0;
         tout_q  <= 1'h0;
         pevt_q  <= 1'h0;
      end else begin
         loop_q  <= TREE_ID_TIMEOUT_I |
                    (loop_q & ~(wr_event & wd[`SBPR_B_LOOP]));
         pfail_q <= cps_fall |
                    (pfail_q & ~(wr_event & wd[`SBPR_B_PFAIL]));
         tout_q  <= STATE_TIMEOUT_I |
                    (tout_q & ~(wr_event & wd[`SBPR_B_TOUT]));
         pevt_q  <= pevt_set |
                    (pevt_q & ~(wr_event & wd[`SBPR_B_PEVT]));
      end
   end

   // ========================================================================
   // outputs to core and link
   // ========================================================================
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         CFG_O             <= '0;
         LINK_IF_EN_O      <= 1'h0;
         LINK_WAKE_O       <= 1'h0;
         STATE_RESET_REQ_O <= 1'h0;
      end else begin
         CFG_O.link_active_selfid <= lps_q & link_active_control_q;
         CFG_O.contender          <= cont_q;
         CFG_O.pwr_class          <= pwr_q;
         CFG_O.accel_en           <= accel_q;
         CFG_O.multi_en           <= multi_q;
         // link control bit has no say in whether the interface runs
         LINK_IF_EN_O      <= lps_q;
         LINK_WAKE_O       <= loop_q & wdog_q & ~lps_q;
         STATE_RESET_REQ_O <= STATE_TIMEOUT_I;
      end
   end

   // ========================================================================
   // read multiplexer
   // ========================================================================
   logic [$clog2(NPORTS)-1:0] ps;
   assign ps = port_sel_q[$clog2(NPORTS)-1:0];

   always_comb begin
      rd_mux = 8'h0;
      if (dp_idx_q == `SBPR_IDX_LINK_CFG) begin
         rd_mux[`SBPR_B_LINK_ACTIVE_CONTROL]                   = link_active_control_q;
         rd_mux[`SBPR_B_CONT]                    = cont_q;
         rd_mux[`SBPR_B_JIT_HI:`SBPR_B_JIT_LO]   = `SBPR_JITTER_VAL;
         rd_mux[`SBPR_B_PWR_HI:`SBPR_B_PWR_LO]   = pwr_q;
      end else if (dp_idx_q == `SBPR_IDX_EVENT) begin
         rd_mux[`SBPR_B_WDOG]  = wdog_q;
         rd_mux[`SBPR_B_SHORT_RESET_REQUEST]  = short_reset_request_q;
         rd_mux[`SBPR_B_LOOP]  = loop_q;
         rd_mux[`SBPR_B_PFAIL] = pfail_q;
         rd_mux[`SBPR_B_TOUT]  = tout_q;
         rd_mux[`SBPR_B_PEVT]  = pevt_q;
         rd_mux[`SBPR_B_ACCEL] = accel_q;
         rd_mux[`SBPR_B_MULTI] = multi_q;
      end else if (dp_idx_q == `SBPR_IDX_PAGE_PORT) begin
         rd_mux[`SBPR_B_PAGE_HI:`SBPR_B_PAGE_LO] = page_q;
         rd_mux[`SBPR_B_PORT_HI:`SBPR_B_PORT_LO] = port_sel_q;
      end else if (dp_idx_q == `SBPR_IDX_PORT_STAT && port_hit) begin
         rd_mux[`SBPR_B_CON]  = PORT_STAT_I[ps].con;
         rd_mux[`SBPR_B_BIAS] = PORT_STAT_I[ps].bias;
         rd_mux[`SBPR_B_DIS]  = dis_q[ps];
      end else if (dp_idx_q == `SBPR_IDX_PORT_CTRL && port_hit) begin
         rd_mux[`SBPR_B_INTEN] = inten_q[ps];
         rd_mux[`SBPR_B_FAULT] = PORT_STAT_I[ps].fault;
      end
   end

   // ========================================================================
   // assertions
   // ========================================================================
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);

   sequence s_sr_begin;
      sr_start;
   endsequence
   sequence s_sr_hold;
      SHORT_RESET_O [*8];
   endsequence

   a_link_report: assert property (##1 CFG_O.link_active_selfid ==
         $past(lps_q & link_active_control_q)) else $error("self-id link bit wrong");
   a_if_follows_lps: assert property (##1 LINK_IF_EN_O == $past(lps_q))
      else $error("link interface enable not following power status");
   a_loop_set: assert property (TREE_ID_TIMEOUT_I |=> loop_q)
      else $error("loop flag not set");
   a_pfail_set: assert property (cps_fall |=> pfail_q)
      else $error("cable power fail flag not set");
   a_tout_reset: assert property (STATE_TIMEOUT_I |=> tout_q && STATE_RESET_REQ_O)
      else $error("state timeout flag or reset request missing");
   a_w1c_keep: assert property (loop_q && !(wr_event && wd[`SBPR_B_LOOP]) |=> loop_q)
      else $error("loop flag lost without clearing write");
   a_resume_evt: assert property (wdog_q && (|RESUME_START_I) |=> pevt_q)
      else $error("resume did not set port event");
   a_wake_link: assert property (loop_q && wdog_q && !lps_q |=> LINK_WAKE_O)
      else $error("link not woken");
   a_sr_start: assert property (s_sr_begin |=> !short_reset_request_q ##0 s_sr_hold)
      else $error("short reset start wrong");
   a_sr_length: assert property ($fell(SHORT_RESET_O) |-> $past(sr_cnt_q) == '0)
      else $error("short reset ended early");

endmodule

// ===== tb/sbpr_link_model.sv
// link layer model facing the phy base registers
// assumes the bench clock; sleep is a one-cycle command from the bench
`timescale 1ns/10ps
module sbpr_link_model (
   input  wire logic clk_i,   // bench clock
   input  wire logic rst_i,   // sync reset, high
   input  wire logic sleep_i, // pulse, drop link power
   input  wire logic wake_i,  // phy asks for the link
   output logic      lps_o    // link power status
);
   logic [1:0] dly_q;

   // ==========================================================
   // power state: leaving sleep takes a few cycles, as a real link does
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lps_o <= 1'h1;
         dly_q <= 2'h0;
      end else if (sleep_i) begin
         lps_o <= 1'h0;
         dly_q <= 2'h0;
      end else if (wake_i && !lps_o) begin
         dly_q <= dly_q + 2'h1;
         lps_o <= (dly_q == 2'h3);
      end
   end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the phy base register bank
// assumes sbpr_pkg compiled first; one 250 MHz clock, ahb-lite master here
`timescale 1ns/10ps
module testbench;
   import sbpr_pkg::*;
   logic             clk, rst, hwrite, link_power_status_input, cable_power_status_input, tree, stout, busrst, arb, sleep;
   logic             hrdy, hresp, wake, sreset, sreq, ifen;
   logic [1:0]       htrans, resume, pdis;
   logic [2:0]       pins;
   logic [31:0]      haddr, hwdata, hrdata, v;
   sbpr_port_t [1:0] pstat;
   sbpr_cfg_t        cfg;
   int               err_count, n_checks, n;

   sbpr_base_regs #(.NPORTS(2)) uut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .HSEL_I(1'h1),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy),
      .HRESP_O(hresp), .LINK_POWER_STATUS_I(link_power_status_input), .CABLE_POWER_STATUS_I(cable_power_status_input),
      .POWER_CLASS_PINS_I(pins), .TREE_ID_TIMEOUT_I(tree), .STATE_TIMEOUT_I(stout),
      .BUS_RESET_I(busrst), .ARB_OPPORTUNITY_I(arb), .RESUME_START_I(resume),
      .PORT_STAT_I(pstat), .CFG_O(cfg), .LINK_IF_EN_O(ifen), .LINK_WAKE_O(wake),
      .SHORT_RESET_O(sreset), .STATE_RESET_REQ_O(sreq), .PORT_DIS_O(pdis));

   sbpr_link_model link (.clk_i(clk), .rst_i(rst), .sleep_i(sleep), .wake_i(wake),
      .lps_o(link_power_status_input));

   // ==========================================================
   // bus task; ready and read data are taken at the rising edge, waits end by watchdog
   task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] rd);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'h1);
      rd = hrdata;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic wr(input logic [31:0] a, d);
      ahb(1'h1, a, d, v);
   endtask

   task automatic rdchk(input logic [31:0] a, e);
      ahb(1'h0, a, 32'h0, v);
      chk($sformatf("reg %h", a), e, v);
   endtask

   // ==========================================================
   // scenarios
   task t_cfg;
      rdchk(32'h10, 32'h85);
      rdchk(32'h14, 32'h00);
      rdchk(32'h1C, 32'h00);
      wr(32'h10, 32'h7A);
      rdchk(32'h10, 32'h42);
      chk("response", 32'h0, 32'(hresp));
      chk("cfg", 32'h28, 32'(cfg));
      chk("link if", 32'h1, 32'(ifen));
      wr(32'h14, 32'h03);
      repeat (2) @(posedge clk);
      chk("cfg enables", 32'h2B, 32'(cfg));
      busrst <= 1'h1;
      @(posedge clk);
      busrst <= 1'h0;
      rdchk(32'h10, 32'h42);
      rdchk(32'h14, 32'h03);
      wr(32'h10, 32'hC2);
      rdchk(32'h10, 32'hC2);
      chk("selfid link", 32'h1, 32'(cfg.link_active_selfid));
   endtask

   task t_events;
      tree <= 1'h1;
      stout <= 1'h1;
      cable_power_status_input <= 1'h0;
      @(posedge clk);
      tree <= 1'h0;
      stout <= 1'h0;
      n = 0;
      repeat (4) begin @(negedge clk); n += sreq; end
      @(posedge clk);
      chk("state reset pulses", 32'h1, n);
      repeat (8) @(posedge clk);
      cable_power_status_input <= 1'h1;
      rdchk(32'h14, 32'h3B);
      wr(32'h14, 32'h03);
      rdchk(32'h14, 32'h3B);
      wr(32'h14, 32'h3B);
      rdchk(32'h14, 32'h03);
   endtask

   task t_short;
      wr(32'h14, 32'h43);
      arb <= 1'h1;
      @(posedge clk);
      arb <= 1'h0;
      n = 0;
      repeat (400) begin @(negedge clk); n += sreset; end
      @(posedge clk);
      chk("short reset cycles", 32'h145, n);
      rdchk(32'h14, 32'h03);
      wr(32'h14, 32'h43);
      busrst <= 1'h1;
      @(posedge clk);
      busrst <= 1'h0;
      rdchk(32'h14, 32'h03);
   endtask

   task t_ports;
      wr(32'h1C, 32'h01);
      wr(32'h24, 32'h10);
      rdchk(32'h24, 32'h10);
      pstat[1].con <= 1'h1;
      repeat (2) @(posedge clk);
      rdchk(32'h14, 32'h07);
      rdchk(32'h20, 32'h04);
      wr(32'h14, 32'h07);
      wr(32'h20, 32'h01);
      rdchk(32'h20, 32'h05);
      chk("port disable", 32'h2, 32'(pdis));
      rdchk(32'h14, 32'h07);
      wr(32'h20, 32'h00);
      wr(32'h14, 32'h07);
      wr(32'h1C, 32'h03);
      rdchk(32'h20, 32'h00);
      wr(32'h1C, 32'hE1);
      rdchk(32'h20, 32'h00);
      rdchk(32'h1C, 32'hE1);
      wr(32'h1C, 32'h00);
   endtask

   task t_wake;
      wr(32'h14, 32'h83);
      resume <= 2'h1;
      @(posedge clk);
      resume <= 2'h0;
      @(posedge clk);
      rdchk(32'h14, 32'h87);
      sleep <= 1'h1;
      tree <= 1'h1;
      @(posedge clk);
      sleep <= 1'h0;
      tree <= 1'h0;
      n = 0;
      repeat (30) begin @(negedge clk); n += wake; end
      @(posedge clk);
      chk("wake seen", 32'h1, 32'(n > 0));
      chk("link if back", 32'h1, 32'(ifen));
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // clock, watchdog, main sequence
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   initial begin
      #200000;
      err_count++;
      report_and_stop;
   end

   initial begin
      rst = 1'h1;
      {htrans, haddr, hwrite, hwdata, resume, pstat} = '0;
      {tree, stout, busrst, arb, sleep} = '0;
      cable_power_status_input = 1'h1;
      pins = 3'h5;
      err_count = 0;
      n_checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_cfg;
      t_events;
      t_short;
      t_ports;
      t_wake;
      report_and_stop;
   end
endmodule
